/* File: verilog/port_power_pkg.sv */
// constants, types and helpers shared by the port-power pad control block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package port_power_pkg;

  // ----------------------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------------------
  localparam int IDX_W = 14;
  localparam logic [13:0] IDX_PULLDOWN = 14'h092E;
  localparam logic [13:0] IDX_DIRECTION = 14'h0932;
  localparam logic [13:0] IDX_OUTPUT = 14'h0936;
  localparam logic [13:0] IDX_INPUT = 14'h093A;
  localparam logic [13:0] IDX_PULLUP = 14'h093E;
  localparam logic [13:0] IDX_SEL1 = 14'h3C00;

  // ----------------------------------------------------------------------------
  // values after reset and field positions
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RST_PULLDOWN = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_OUTPUT = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_SEL1 = 8'h00;
  localparam logic [7:0] SEL1_WRITE_MASK = 8'hBF;
  localparam logic [7:0] PULLUP_WRITE_MASK = 8'hFE;
  localparam int SEL_COMBINED_BIT = 7;
  localparam int SEL_DISABLE_BIT = 5;
  localparam int SEL_NONREM_BIT = 4;
  localparam int SEL_SRC_LSB = 0;
  localparam int SEL_SRC_MSB = 3;

  // ----------------------------------------------------------------------------
  // power source codes
  // ----------------------------------------------------------------------------
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_USB2 = 4'h1;
  localparam logic [3:0] SRC_USB3 = 4'h2;
  localparam logic [3:0] SRC_EITHER = 4'h3;
  localparam logic [3:0] SRC_GPIO = 4'h4;

  // ----------------------------------------------------------------------------
  // bus slave states and carriers
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SLAVE_IDLE,
    SLAVE_WRITE,
    SLAVE_READ_WAIT,
    SLAVE_READ_DONE
  } slave_state_e;

  typedef struct packed {
    logic [7:1] out_data;
    logic [7:1] out_enable;
    logic [7:1] pullup_en;
    logic [7:1] pulldown_en;
  } pad_ctrl_s;

  typedef struct packed {
    logic power_on;
    logic disabled;
    logic non_removable;
    logic combined_mode;
  } port1_status_s;

  // true for a word-aligned, in-range byte address
  function automatic logic addr_in_map(input logic [31:0] addr);
    return (addr[31:16] == 16'h0000) && (addr[1:0] == 2'h0);
  endfunction

  // port power decision from the source code and live sources
  function automatic logic source_power(input logic [3:0] code, input logic usb2,
                                        input logic usb3, input logic gpio);
    case (code)
      SRC_USB2: return usb2;
      SRC_USB3: return usb3;
      SRC_EITHER: return usb2 | usb3;
      SRC_GPIO: return gpio;
      default: return 1'b0;
    endcase
  endfunction

endpackage

/* File: verilog/pad_level_sync.sv */
// three-stage synchroniser with agreement filter for pad input levels
`timescale 1ns/1ps
module pad_level_sync #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // accept a change only once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
    end
  end

  // stage one is read by stage two only
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule

/* File: verilog/ahb_word_slave.sv */
// AHB-Lite word slave front end: writes with no wait, reads with one wait
`timescale 1ns/1ps
module ahb_word_slave (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register side
  output logic wr_en,
  output logic [13:0] reg_index,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);

  port_power_pkg::slave_state_e state_reg, state_next;
  logic [13:0] index_reg, index_next;
  logic mapped_reg, mapped_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic accept;

  // one wait on reads lets a write in the prior data phase land first
  assign hreadyout = (state_reg != port_power_pkg::SLAVE_READ_WAIT);
  assign accept = hsel && htrans[1] && hready;

  // next state, captured address and read data
  always_comb begin
    state_next = state_reg;
    index_next = index_reg;
    mapped_next = mapped_reg;
    hrdata_next = hrdata_reg;
    if (state_reg == port_power_pkg::SLAVE_READ_WAIT) begin
      hrdata_next = mapped_reg ? {24'h000000, rd_data} : 32'h00000000;
    end
    case (state_reg)
      port_power_pkg::SLAVE_READ_WAIT: state_next = port_power_pkg::SLAVE_READ_DONE;
      port_power_pkg::SLAVE_IDLE,
      port_power_pkg::SLAVE_WRITE,
      port_power_pkg::SLAVE_READ_DONE: begin
        state_next = port_power_pkg::SLAVE_IDLE;
        if (accept) begin
          state_next = hwrite ? port_power_pkg::SLAVE_WRITE : port_power_pkg::SLAVE_READ_WAIT;
          index_next = haddr[15:2];
          mapped_next = port_power_pkg::addr_in_map(haddr) && (hsize == 3'h2);
        end
      end
      default: state_next = port_power_pkg::SLAVE_IDLE;
    endcase
  end

  // registers of the bus front end
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= port_power_pkg::SLAVE_IDLE;
      index_reg <= 14'h0000;
      mapped_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      index_reg <= index_next;
      mapped_reg <= mapped_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // unmapped writes are dropped, unmapped reads return zero
  assign wr_en = (state_reg == port_power_pkg::SLAVE_WRITE) && mapped_reg;
  assign reg_index = index_reg;
  assign wr_data = hwdata[7:0];
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;

endmodule

/* File: verilog/port_power_pin_control.sv */
// register file and pad control for the seven port-power pads and port 1 select
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module port_power_pin_control (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // port-power pads, index n is pad n
  input wire logic [7:1] pad_in,
  output port_power_pkg::pad_ctrl_s pads,
  // port 1 power sources from hub logic
  input wire logic usb2_port_power,
  input wire logic usb3_port_power,
  input wire logic designated_gpio,
  // port 1 state
  output port_power_pkg::port1_status_s port1
);

  // ----------------------------------------------------------------------------
  // bus front end and input synchroniser
  // ----------------------------------------------------------------------------
  logic wr_en;
  logic [13:0] reg_index;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:1] in_level;

  ahb_word_slave u_bus (
    .clk(clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr_en(wr_en),
    .reg_index(reg_index),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  pad_level_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(pad_in),
    .level(in_level)
  );

  // ----------------------------------------------------------------------------
  // pad registers
  // ----------------------------------------------------------------------------
  logic [7:0] pulldown_reg, pulldown_next;
  logic [7:0] direction_reg, direction_next;
  logic [7:0] output_reg, output_next;
  logic [7:0] pullup_reg, pullup_next;
  logic [7:0] sel1_reg, sel1_next;

  // bit 0 of the first three is stored but never reaches a pad
  always_comb begin
    pulldown_next = pulldown_reg;
    direction_next = direction_reg;
    output_next = output_reg;
    pullup_next = pullup_reg;
    sel1_next = sel1_reg;
    if (wr_en) begin
      case (reg_index)
        port_power_pkg::IDX_PULLDOWN: pulldown_next = wr_data;
        port_power_pkg::IDX_DIRECTION: direction_next = wr_data;
        port_power_pkg::IDX_OUTPUT: output_next = wr_data;
        port_power_pkg::IDX_PULLUP: pullup_next = wr_data & port_power_pkg::PULLUP_WRITE_MASK;
        port_power_pkg::IDX_SEL1: sel1_next = wr_data & port_power_pkg::SEL1_WRITE_MASK;
        default: pulldown_next = pulldown_reg; // input register and holes ignore writes
      endcase
    end
  end

  // register storage
  always_ff @(posedge clk) begin
    if (reset) begin
      pulldown_reg <= port_power_pkg::RST_PULLDOWN;
      direction_reg <= port_power_pkg::RST_DIRECTION;
      output_reg <= port_power_pkg::RST_OUTPUT;
      pullup_reg <= port_power_pkg::RST_PULLUP;
      sel1_reg <= port_power_pkg::RST_SEL1;
    end else begin
      pulldown_reg <= pulldown_next;
      direction_reg <= direction_next;
      output_reg <= output_next;
      pullup_reg <= pullup_next;
      sel1_reg <= sel1_next;
    end
  end

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  // reserved read-only bits come back as zero
  always_comb begin
    case (reg_index)
      port_power_pkg::IDX_PULLDOWN: rd_data = pulldown_reg;
      port_power_pkg::IDX_DIRECTION: rd_data = direction_reg;
      port_power_pkg::IDX_OUTPUT: rd_data = output_reg;
      port_power_pkg::IDX_INPUT: rd_data = {in_level, 1'b0};
      port_power_pkg::IDX_PULLUP: rd_data = pullup_reg;
      port_power_pkg::IDX_SEL1: rd_data = sel1_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------------
  // pad drive, straight from the registers bit for bit
  // ----------------------------------------------------------------------------
  // output data is always presented; enable alone decides whether it drives
  assign pads.out_data = output_reg[7:1];
  assign pads.out_enable = direction_reg[7:1];
  assign pads.pullup_en = pullup_reg[7:1];
  assign pads.pulldown_en = pulldown_reg[7:1];

  // ----------------------------------------------------------------------------
  // port 1 power and status
  // ----------------------------------------------------------------------------
  port_power_pkg::port1_status_s port1_reg, port1_next;
  logic [3:0] src_code;

  assign src_code = sel1_reg[port_power_pkg::SEL_SRC_MSB:port_power_pkg::SEL_SRC_LSB];

  // settings are static after configuration, so live changes need no guarding
  always_comb begin
    port1_next.power_on = port_power_pkg::source_power(src_code, usb2_port_power,
                                                       usb3_port_power, designated_gpio) &&
                          !sel1_reg[port_power_pkg::SEL_DISABLE_BIT];
    port1_next.disabled = sel1_reg[port_power_pkg::SEL_DISABLE_BIT];
    port1_next.non_removable = sel1_reg[port_power_pkg::SEL_NONREM_BIT];
    port1_next.combined_mode = sel1_reg[port_power_pkg::SEL_COMBINED_BIT];
  end

  // registered status outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      port1_reg <= '0;
    end else begin
      port1_reg <= port1_next;
    end
  end

  assign port1 = port1_reg;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence wr_to(logic [13:0] idx);
    wr_en && (reg_index == idx);
  endsequence

  // the synchroniser restarts from zero at reset, so settled time only counts once out of reset
  sequence in_settled;
    (!reset && $stable(pad_in)) [*5];
  endsequence

  AST_PULLDOWN_WRITE: assert property (wr_to(port_power_pkg::IDX_PULLDOWN) |=>
    pads.pulldown_en == $past(wr_data[7:1])) else $error("pull-down not updated");

  AST_PAD_ONE_MAP: assert property (wr_to(port_power_pkg::IDX_PULLUP) ##1 1'b1 |->
    pads.pullup_en[1] == $past(wr_data[1])) else $error("bit 1 not on pad 1");

  AST_DIRECTION_WRITE: assert property (wr_to(port_power_pkg::IDX_DIRECTION) |=>
    pads.out_enable == $past(wr_data[7:1])) else $error("direction not updated");

  AST_OUTPUT_WRITE: assert property (wr_to(port_power_pkg::IDX_OUTPUT) |=>
    pads.out_data == $past(wr_data[7:1])) else $error("output data not updated");

  AST_INPUT_LEVEL: assert property (in_settled |-> in_level == pad_in)
    else $error("input level not tracking pad");

  AST_INPUT_READ: assert property ((reg_index == port_power_pkg::IDX_INPUT) |->
    rd_data == {in_level, 1'b0}) else $error("input register read wrong");

  AST_PULLUP_BIT0: assert property (wr_to(port_power_pkg::IDX_PULLUP) |=>
    (pullup_reg[0] == 1'b0) && (pads.pullup_en == $past(wr_data[7:1]))) else $error("pull-up write wrong");

  AST_COMBINED: assert property (wr_to(port_power_pkg::IDX_SEL1) ##2 1'b1 |->
    port1.combined_mode == $past(wr_data[7], 2)) else $error("combined mode not applied");

  AST_DISABLED_OFF: assert property ($past(sel1_reg[port_power_pkg::SEL_DISABLE_BIT]) |->
    port1.disabled && !port1.power_on) else $error("disabled port powered");

  AST_NONREM: assert property (port1.non_removable == $past(sel1_reg[4]))
    else $error("non-removable flag wrong");

  AST_SRC_EITHER: assert property ((src_code == port_power_pkg::SRC_EITHER) && !sel1_reg[5] |=>
    port1.power_on == ($past(usb2_port_power) || $past(usb3_port_power))) else $error("either source wrong");

  AST_SRC_RESERVED: assert property ((src_code > port_power_pkg::SRC_GPIO) |=> !port1.power_on)
    else $error("reserved source powered port");

  AST_INPUT_HOLD: assert property (wr_to(port_power_pkg::IDX_OUTPUT) && !direction_reg[1] |=>
    !pads.out_enable[1] && (output_reg[1] == $past(wr_data[1]))) else $error("input pad driven");

  AST_SEL_BIT6: assert property (wr_to(port_power_pkg::IDX_SEL1) |=> sel1_reg[6] == 1'b0)
    else $error("read-only bit written");

  // ----------------------------------------------------------------------------
  // pad controls hold between writes
  // ----------------------------------------------------------------------------
  // a pad setting that moved without its own write would glitch the switch
  AST_PULLDOWN_HOLD: assert property (
    !(wr_en && (reg_index == port_power_pkg::IDX_PULLDOWN)) |=> $stable(pads.pulldown_en))
    else $error("pull-down moved without write");

  AST_DIRECTION_HOLD: assert property (
    !(wr_en && (reg_index == port_power_pkg::IDX_DIRECTION)) |=> $stable(pads.out_enable))
    else $error("direction moved without write");

  AST_OUTPUT_HOLD: assert property (
    !(wr_en && (reg_index == port_power_pkg::IDX_OUTPUT)) |=> $stable(pads.out_data))
    else $error("output data moved without write");

  AST_PULLUP_HOLD: assert property (
    !(wr_en && (reg_index == port_power_pkg::IDX_PULLUP)) |=> $stable(pads.pullup_en))
    else $error("pull-up moved without write");

  AST_PULLUP_RESERVED: assert property (
    pullup_reg[0] == 1'b0)
    else $error("pull-up reserved bit set");

  AST_INPUT_NO_WRITE: assert property (
    wr_to(port_power_pkg::IDX_INPUT) |=> $stable({pulldown_reg, direction_reg, output_reg, pullup_reg, sel1_reg}))
    else $error("input register write changed state");

  // ----------------------------------------------------------------------------
  // reserved bit 0 storage and read-back
  // ----------------------------------------------------------------------------
  AST_PULLDOWN_BIT0: assert property (
    wr_to(port_power_pkg::IDX_PULLDOWN) |=> pulldown_reg[0] == $past(wr_data[0]))
    else $error("pull-down bit 0 not stored");

  AST_DIRECTION_BIT0: assert property (
    wr_to(port_power_pkg::IDX_DIRECTION) |=> direction_reg[0] == $past(wr_data[0]))
    else $error("direction bit 0 not stored");

  AST_OUTPUT_READBACK: assert property (
    (reg_index == port_power_pkg::IDX_OUTPUT) |-> rd_data == output_reg)
    else $error("output register read wrong");

  // ----------------------------------------------------------------------------
  // port 1 status and source selection
  // ----------------------------------------------------------------------------
  // status bits lag the select register by exactly one registered stage
  AST_DISABLED_FLAG: assert property (
    port1.disabled == $past(sel1_reg[port_power_pkg::SEL_DISABLE_BIT]))
    else $error("disabled flag wrong");

  AST_COMBINED_FOLLOW: assert property (
    port1.combined_mode == $past(sel1_reg[port_power_pkg::SEL_COMBINED_BIT]))
    else $error("combined mode flag wrong");

  AST_DISABLED_SET: assert property (
    wr_to(port_power_pkg::IDX_SEL1) ##2 1'b1 |-> port1.disabled == $past(wr_data[5], 2))
    else $error("disable write not applied");

  AST_NONREM_SET: assert property (
    wr_to(port_power_pkg::IDX_SEL1) ##2 1'b1 |-> port1.non_removable == $past(wr_data[4], 2))
    else $error("non-removable write not applied");

  AST_SRC_OFF: assert property (
    (src_code == port_power_pkg::SRC_OFF) |=> !port1.power_on)
    else $error("off source powered port");

  AST_SRC_USB2: assert property (
    (src_code == port_power_pkg::SRC_USB2) && !sel1_reg[port_power_pkg::SEL_DISABLE_BIT] |=>
    port1.power_on == $past(usb2_port_power)) else $error("usb2 source wrong");

  AST_SRC_USB3: assert property (
    (src_code == port_power_pkg::SRC_USB3) && !sel1_reg[port_power_pkg::SEL_DISABLE_BIT] |=>
    port1.power_on == $past(usb3_port_power)) else $error("usb3 source wrong");

  AST_SRC_GPIO: assert property (
    (src_code == port_power_pkg::SRC_GPIO) && !sel1_reg[port_power_pkg::SEL_DISABLE_BIT] |=>
    port1.power_on == $past(designated_gpio)) else $error("pin source wrong");

endmodule

/* File: tb/pad_switch_model.sv */
// behavioural port power switches and sense lines seen on the seven pads
`timescale 1ns/1ps
module pad_switch_model (
  // pad controls from the block
  input wire port_power_pkg::pad_ctrl_s pads,
  // level forced by an outside switch or sensor
  input wire logic [7:1] ext_en,
  input wire logic [7:1] ext_val,
  // resolved pad levels
  output logic [7:1] pad_in
);
  // ----------------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------------
  // a pad nobody drives and nothing pulls shows the inverse of the stored
  // output bit, so a stale copy of it can never pass for a match
  always_comb begin
    for (int n = 1; n <= 7; n++) begin
      if (pads.out_enable[n]) begin
        pad_in[n] = pads.out_data[n];
      end else if (ext_en[n]) begin
        pad_in[n] = ext_val[n];
      end else if (pads.pullup_en[n]) begin
        pad_in[n] = 1'b1;
      end else if (pads.pulldown_en[n]) begin
        pad_in[n] = 1'b0;
      end else begin
        pad_in[n] = ~pads.out_data[n];
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the port-power pad control block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  // ----------------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:1] pad_in;
  logic [7:1] ext_en = 7'h00;
  logic [7:1] ext_val = 7'h00;
  logic usb2 = 1'b0;
  logic usb3 = 1'b0;
  logic gpio = 1'b0;
  port_power_pkg::pad_ctrl_s pads;
  port_power_pkg::port1_status_s port1;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rdv;
  logic [7:0] sh [4] = '{8'h00, 8'h00, 8'h00, 8'h00}; // shadow: pull-down, direction, output, pull-up
  logic [13:0] regs [4] = '{port_power_pkg::IDX_PULLDOWN, port_power_pkg::IDX_DIRECTION,
                            port_power_pkg::IDX_OUTPUT, port_power_pkg::IDX_PULLUP};

  // ----------------------------------------------------------------------------
  // clock, instances, timeout
  // ----------------------------------------------------------------------------
  always #2 clk = ~clk;

  port_power_pin_control i_port_power_pin_control (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pad_in(pad_in), .pads(pads), .usb2_port_power(usb2),
    .usb3_port_power(usb3), .designated_gpio(gpio), .port1(port1));

  pad_switch_model i_pad_switch_model (.pads(pads), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // the whole run needs under a thousand cycles; a hang ends here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] ra(input logic [13:0] i);
    return {16'h0000, i, 2'h0};
  endfunction

  function automatic port_power_pkg::pad_ctrl_s exp_pads();
    return {sh[2][7:1], sh[1][7:1], sh[3][7:1], sh[0][7:1]};
  endfunction

  // one single transfer; entered right after a rising edge, leaves at one
  task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    bus(ra(i), 1'b1, 3'h2, {24'h0, d}, rdv);
  endtask

  task automatic rdc(input logic [13:0] i, input logic [7:0] e);
    bus(ra(i), 1'b0, 3'h2, 32'h0, rdv);
    `CHK(rdv, {24'h0, e})
  endtask

  // look at the pads mid-cycle, then return on a rising edge
  task automatic chk_pads();
    @(negedge clk);
    `CHK(pads, exp_pads())
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    `CHK(hreadyout, 1'b1)
    `CHK(pads, 28'h0)
    `CHK(port1, 4'h0)
    for (int r = 0; r < 4; r++) rdc(regs[r], 8'h00);
    rdc(port_power_pkg::IDX_SEL1, 8'h00);
  endtask

  // walking one through every bit of the four pad registers, bit 0 too
  task automatic t_pads();
    logic [7:0] v;
    for (int r = 0; r < 4; r++) begin
      for (int n = 0; n < 8; n++) begin
        v = 8'h01 << n;
        wr(regs[r], v);
        sh[r] = (r == 3) ? (v & 8'hFE) : v;
        chk_pads();
        rdc(regs[r], sh[r]);
      end
    end
  endtask

  task automatic t_input();
    wr(port_power_pkg::IDX_DIRECTION, 8'h00);
    sh[1] = 8'h00;
    wr(port_power_pkg::IDX_OUTPUT, 8'hAA);
    sh[2] = 8'hAA;
    chk_pads();
    ext_en <= 7'h7F;
    ext_val <= 7'h35;
    repeat (6) @(posedge clk);
    rdc(port_power_pkg::IDX_INPUT, 8'h6A);
    wr(port_power_pkg::IDX_INPUT, 8'hFF);
    rdc(port_power_pkg::IDX_INPUT, 8'h6A);
    rdc(port_power_pkg::IDX_OUTPUT, 8'hAA);
    wr(port_power_pkg::IDX_DIRECTION, 8'hFE);
    sh[1] = 8'hFE;
    repeat (6) @(posedge clk);
    rdc(port_power_pkg::IDX_INPUT, 8'hAA);
    wr(port_power_pkg::IDX_DIRECTION, 8'h00);
    wr(port_power_pkg::IDX_PULLUP, 8'hFE);
    ext_en <= 7'h00;
    repeat (6) @(posedge clk);
    rdc(port_power_pkg::IDX_INPUT, 8'hFE);
  endtask

  // every source code against every mix of live sources
  task automatic t_sel();
    logic [7:0] v;
    logic [3:0] c;
    logic [2:0] s;
    logic pw;
    wr(port_power_pkg::IDX_SEL1, 8'hFF);
    rdc(port_power_pkg::IDX_SEL1, 8'hBF);
    @(negedge clk);
    `CHK(port1, 4'h7)
    @(posedge clk);
    usb2 <= 1'b1;
    wr(port_power_pkg::IDX_SEL1, 8'h21);
    @(posedge clk);
    @(negedge clk);
    `CHK(port1, 4'h4)
    @(posedge clk);
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      v = {c[0], 2'b00, c[1], c};
      wr(port_power_pkg::IDX_SEL1, v);
      for (int j = 0; j < 8; j++) begin
        s = j[2:0];
        usb2 <= s[0];
        usb3 <= s[1];
        gpio <= s[2];
        @(posedge clk);
        @(negedge clk);
        pw = (c == 4'h1) ? s[0] : (c == 4'h2) ? s[1] : (c == 4'h3) ? (s[0] | s[1]) : (c == 4'h4) ? s[2] : 1'b0;
        `CHK(port1, {pw, 1'b0, c[1], c[0]})
        @(posedge clk);
      end
    end
  endtask

  // unmapped, misaligned, byte-sized and out-of-range accesses change nothing
  task automatic t_unmapped();
    bus(ra(port_power_pkg::IDX_PULLDOWN) + 32'h4, 1'b1, 3'h2, 32'hFF, rdv);
    bus(ra(port_power_pkg::IDX_PULLDOWN) + 32'h4, 1'b0, 3'h2, 32'h0, rdv);
    `CHK(rdv, 32'h0)
    bus(ra(port_power_pkg::IDX_PULLDOWN) | 32'h1, 1'b1, 3'h2, 32'h5A, rdv);
    bus(ra(port_power_pkg::IDX_PULLDOWN), 1'b1, 3'h0, 32'h5A, rdv);
    rdc(port_power_pkg::IDX_PULLDOWN, sh[0]);
    bus(ra(port_power_pkg::IDX_PULLDOWN) | 32'h10000, 1'b0, 3'h2, 32'h0, rdv);
    `CHK(rdv, 32'h0)
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_pads();
    t_input();
    t_sel();
    t_unmapped();
    give_verdict();
  end
endmodule
